// >>> verilog/csc_ctrl.sv
// Notes on behaviour
// - Module-on bit enables whole sensing unit, clearing it disables.
// - Range 00 stops oscillator; 01/10/11 pick low/medium/high current.
// - Read-only direction bit: 1 sourcing current, 0 sinking.
// - Timer0 external mode: source bit picks oscillator or clock pin.
// - Timer0 internal mode: source bit ignored, instruction clock used.
// - When enabled, channel codes 0 to 11 pick sensing input.
// - When disabled, channel field ignored and no input connected.
// - Oscillator keeps running while enabled, even in sleep.
// - Timer0 is halted during sleep.
// - Unused upper register bits read zero, writes ignored.
// - All implemented bits clear to zero on every reset.
// - Timer1 source code 11 clocks Timer1 from sensing oscillator.
// - Enabled module places oscillator on selected input pin.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module csc_ctrl
  import csc_pkg::*;
#(
  parameter int NUM_CH = CSC_NUM_CH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire csc_pkg::csc_bus_req_t bus_req,
  output logic [7:0] rdata,
  // Core and timer configuration
  input wire logic sleep_mode,
  input wire logic timer0_clock_source_sel,
  input wire logic [1:0] timer1_clock_source_sel,
  // Analog oscillator side
  input wire logic osc_direction_raw,
  output csc_pkg::csc_osc_ctl_t osc_ctl,
  output logic [NUM_CH-1:0] sense_input_pin,
  // Timer clock pin and count pulses
  input wire logic timer0_clock_pin,
  output logic timer0_count_pulse,
  output logic timer1_count_pulse
);
  import csc_pkg::*;

  localparam int ICLK_W = $clog2(CSC_ICLK_DIV);
  localparam logic [ICLK_W-1:0] ICLK_LAST = ICLK_W'(CSC_ICLK_DIV - 1);

  logic sense_module_on_ff;
  logic [1:0] osc_current_range_ff;
  logic timer0_ext_source_sel_ff;
  logic [3:0] sense_channel_field_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [ICLK_W-1:0] iclk_cnt_ff;
  logic iclk_tick;
  logic dir_sync;
  logic osc_rise;
  logic pin_rise;
  logic osc_edge_ok;
  logic [NUM_CH-1:0] nxt_pins;
  logic [NUM_CH-1:0] pins_ff;
  logic t0_pulse_ff;
  logic t1_pulse_ff;
  csc_range_t rng;

  // Main control register writes
  // reset clears fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_module_on_ff <= CSC_MAIN_RST[CSC_ON_BIT];
      osc_current_range_ff <= CSC_MAIN_RST[CSC_RNG_LSB+:2];
      timer0_ext_source_sel_ff <= CSC_MAIN_RST[CSC_XCS_BIT];
    end else if (clk_en && bus_req.wr && bus_req.addr == CSC_REG_MAIN) begin
      sense_module_on_ff <= bus_req.wdata[CSC_ON_BIT];
      osc_current_range_ff <= bus_req.wdata[CSC_RNG_LSB+:2];
      timer0_ext_source_sel_ff <= bus_req.wdata[CSC_XCS_BIT];
    end
  end

  // Channel register writes, stored as written
  // reset clears channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_channel_field_ff <= CSC_CHAN_RST[3:0];
    end else if (clk_en && bus_req.wr && bus_req.addr == CSC_REG_CHAN) begin
      sense_channel_field_ff <= bus_req.wdata[3:0];
    end
  end

  // Read data mux
  // unused bits zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus_req.addr == CSC_REG_MAIN) begin
      nxt_rdata[CSC_ON_BIT] = sense_module_on_ff;
      nxt_rdata[CSC_RNG_LSB+:2] = osc_current_range_ff;
      nxt_rdata[CSC_DIR_BIT] = dir_sync;
      nxt_rdata[CSC_XCS_BIT] = timer0_ext_source_sel_ff;
    end else if (bus_req.addr == CSC_REG_CHAN) begin
      nxt_rdata[3:0] = sense_channel_field_ff;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      rdata_ff <= bus_req.rd ? nxt_rdata : 8'h00;
    end
  end
  assign rdata = rdata_ff;

  // Current range decode
  // unit gated by enable
  assign rng = csc_range_t'(osc_current_range_ff);
  always_comb begin
    osc_ctl = '0;
    if (sense_module_on_ff) begin
      case (rng)
        CSC_RNG_LOW: osc_ctl = '{1'b1, 1'b1, 1'b0, 1'b0};
        CSC_RNG_MED: osc_ctl = '{1'b1, 1'b0, 1'b1, 1'b0};
        CSC_RNG_HIGH: osc_ctl = '{1'b1, 1'b0, 1'b0, 1'b1};
        default: osc_ctl = '0;
      endcase
    end
  end

  // Channel select, one enable per input pad
  // binary index decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign nxt_pins[gi] = sense_module_on_ff &&
        (sense_channel_field_ff == 4'(gi));
    end
  endgenerate

  // Pad select register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_ff <= '0;
    end else if (clk_en) begin
      pins_ff <= nxt_pins;
    end
  end
  assign sense_input_pin = pins_ff;

  // Direction synchroniser with edge detect
  // one count per period
  csc_edge_sync u_dir_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(osc_direction_raw),
    .sync_out(dir_sync),
    .rise_pulse(osc_rise)
  );

  // Timer0 clock pin synchroniser
  csc_edge_sync u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(timer0_clock_pin),
    .sync_out(),
    .rise_pulse(pin_rise)
  );

  assign osc_edge_ok = osc_rise & osc_ctl.osc_run;

  // Instruction clock divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iclk_cnt_ff <= '0;
    end else if (clk_en) begin
      iclk_cnt_ff <= (iclk_cnt_ff == ICLK_LAST) ? '0 : iclk_cnt_ff + 1'b1;
    end
  end
  assign iclk_tick = clk_en && (iclk_cnt_ff == ICLK_LAST);

  // Timer0 count source select
  // external source choice
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t0_pulse_ff <= 1'b0;
    end else if (clk_en) begin
      if (sleep_mode) begin
        t0_pulse_ff <= 1'b0;
      end else if (!timer0_clock_source_sel) begin
        t0_pulse_ff <= iclk_tick;
      end else if (timer0_ext_source_sel_ff) begin
        t0_pulse_ff <= osc_edge_ok;
      end else begin
        t0_pulse_ff <= pin_rise;
      end
    end
  end
  assign timer0_count_pulse = t0_pulse_ff & clk_en;

  // Timer1 oscillator count, kept in sleep
  // Timer1 source code 11
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_pulse_ff <= 1'b0;
    end else if (clk_en) begin
      t1_pulse_ff <= osc_edge_ok &&
        (timer1_clock_source_sel == CSC_T1_SRC_OSC);
    end
  end
  assign timer1_count_pulse = t1_pulse_ff & clk_en;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_main_wr;
    clk_en && bus_req.wr && bus_req.addr == CSC_REG_MAIN;
  endsequence
  sequence s_main_rd;
    clk_en && bus_req.rd && bus_req.addr == CSC_REG_MAIN;
  endsequence

  sequence s_t1_sleep_edge;
    clk_en && sleep_mode && osc_edge_ok &&
      timer1_clock_source_sel == CSC_T1_SRC_OSC;
  endsequence

  en_write_a: assert property (
    s_main_wr |=> osc_ctl.osc_run == ($past(bus_req.wdata[CSC_ON_BIT]) &&
      $past(bus_req.wdata[CSC_RNG_LSB+:2]) != 2'h0))
    else $error("enable or range write not applied");

  range_decode_a: assert property (
    osc_ctl.cur_high |-> sense_module_on_ff &&
      osc_current_range_ff == 2'h3 && !osc_ctl.cur_low)
    else $error("high range decode wrong");

  dir_read_a: assert property (
    s_main_rd |=> rdata[CSC_DIR_BIT] == $past(dir_sync))
    else $error("direction status not reported");

  t0_src_a: assert property (
    clk_en && !sleep_mode && timer0_clock_source_sel &&
    !timer0_ext_source_sel_ff && pin_rise ##1 clk_en |-> timer0_count_pulse)
    else $error("timer0 pin edge not counted");

  t0_iclk_a: assert property (
    clk_en && !sleep_mode && !timer0_clock_source_sel && !iclk_tick
    ##1 clk_en |-> !timer0_count_pulse)
    else $error("timer0 counted off instruction clock");

  chan_sel_a: assert property (
    clk_en && sense_module_on_ff && sense_channel_field_ff <= CSC_CH_MAX
    |=> $onehot(sense_input_pin))
    else $error("channel not selected");

  chan_off_a: assert property (
    clk_en && !sense_module_on_ff |=> sense_input_pin == '0)
    else $error("channel selected while disabled");

  sleep_halt_a: assert property (
    clk_en && sleep_mode |=> !timer0_count_pulse)
    else $error("timer0 counted in sleep");

  upper_zero_a: assert property (
    clk_en && bus_req.rd |=> rdata[6:4] == 3'h0 &&
      ($past(bus_req.addr) != CSC_REG_CHAN || rdata[7:4] == 4'h0))
    else $error("unused bits read nonzero");

  t1_src_a: assert property (
    timer1_count_pulse |-> $past(timer1_clock_source_sel) == CSC_T1_SRC_OSC)
    else $error("timer1 counted from wrong source");

  one_count_a: assert property (
    timer1_count_pulse ##1 clk_en |-> !timer1_count_pulse)
    else $error("double count per period");

  chan_index_a: assert property (
    clk_en && sense_module_on_ff && sense_channel_field_ff <= CSC_CH_MAX
    |=> sense_input_pin[$past(sense_channel_field_ff)])
    else $error("selected pad not driven");

  t0_tick_a: assert property (
    clk_en && !sleep_mode && !timer0_clock_source_sel && iclk_tick
    ##1 clk_en |-> timer0_count_pulse)
    else $error("timer0 missed instruction clock");

  osc_off_a: assert property (
    clk_en && !osc_ctl.osc_run |=> !timer1_count_pulse)
    else $error("oscillator edge counted while off");

  t1_sleep_a: assert property (
    s_t1_sleep_edge ##1 clk_en |-> timer1_count_pulse)
    else $error("timer1 lost count in sleep");

endmodule : csc_ctrl

// >>> verilog/csc_pkg.sv
package csc_pkg;

  // Register indices
  localparam logic [1:0] CSC_REG_MAIN = 2'h0;
  localparam logic [1:0] CSC_REG_CHAN = 2'h1;
  localparam int CSC_ADDR_W = 2;

  // Field positions in the main control register
  localparam int CSC_ON_BIT = 7;
  localparam int CSC_RNG_LSB = 2;
  localparam int CSC_DIR_BIT = 1;
  localparam int CSC_XCS_BIT = 0;

  // Reset values
  localparam logic [7:0] CSC_MAIN_RST = 8'h00;
  localparam logic [7:0] CSC_CHAN_RST = 8'h00;

  // Channel count and last legal code
  localparam int CSC_NUM_CH = 12;
  localparam logic [3:0] CSC_CH_MAX = 4'hB;

  // Instruction clock divide ratio
  localparam int CSC_ICLK_DIV = 4;

  // Oscillator current range codes
  typedef enum logic [1:0] {
    CSC_RNG_OFF = 2'h0,
    CSC_RNG_LOW = 2'h1,
    CSC_RNG_MED = 2'h2,
    CSC_RNG_HIGH = 2'h3
  } csc_range_t;

  // Timer1 source code that picks the sensing oscillator
  localparam logic [1:0] CSC_T1_SRC_OSC = 2'h3;

  // Software register bus request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csc_bus_req_t;

  // Decoded current-source controls
  typedef struct packed {
    logic osc_run;
    logic cur_low;
    logic cur_med;
    logic cur_high;
  } csc_osc_ctl_t;

endpackage : csc_pkg

// >>> verilog/csc_edge_sync.sv
`timescale 1ns/1ps
module csc_edge_sync
  import csc_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Asynchronous level in
  input wire logic async_in,
  // Synchronised level and rising edge
  output logic sync_out,
  output logic rise_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign sync_out = sync_ff;
  assign rise_pulse = clk_en & sync_ff & ~last_ff;

endmodule : csc_edge_sync

// >>> dv/csc_pad_model.sv
`timescale 1ns/1ps
module csc_pad_model (
  // Clock
  input wire logic clk,
  // Control from bench
  input wire logic run,
  input wire logic idle,
  input wire logic load,
  // Oscillator direction and timer pin
  output logic osc_dir,
  output logic pin
);
  int c;
  // phases of at least three cycles
  always_ff @(posedge clk) begin
    if (!run) begin
      c <= 0;
      osc_dir <= idle;
      pin <= 1'b0;
    end else begin
      c <= c + 1;
      // Period of 8 cycles, 10 when the pad is loaded
      if (c % (load ? 5 : 4) == (load ? 4 : 3)) osc_dir <= ~osc_dir;
      if (c % 3 == 2) pin <= ~pin; // Period of 6 cycles
    end
  end
endmodule : csc_pad_model

// >>> dv/csc_ctrl_bench.sv
`timescale 1ns/1ps
module csc_ctrl_bench;
  import csc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, sleep_mode = 1'b0;
  logic t0_sel = 1'b0, run = 1'b0, idle = 1'b0, load = 1'b0;
  logic dir, pin, p_osc, p_pin;
  logic [1:0] t1_sel = 2'h0;
  csc_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  csc_osc_ctl_t osc_ctl;
  logic [11:0] pads;
  logic t0_pulse, t1_pulse;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  int n0, n1, r_osc, r_pin, u, thr;
  logic [3:0] ctl_exp [4] = '{4'h0, 4'hC, 4'hA, 4'h9};
  always #5 clk = ~clk;
  csc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus_req(bus_req), .rdata(rdata), .sleep_mode(sleep_mode),
    .timer0_clock_source_sel(t0_sel), .timer1_clock_source_sel(t1_sel),
    .osc_direction_raw(dir), .osc_ctl(osc_ctl), .sense_input_pin(pads),
    .timer0_clock_pin(pin), .timer0_count_pulse(t0_pulse),
    .timer1_count_pulse(t1_pulse));
  csc_pad_model pad (.clk(clk), .run(run), .idle(idle), .osc_dir(dir),
    .pin(pin), .load(load));
  // Counts of pulses and stimulus rises
  always @(posedge clk) begin
    n0 += (t0_pulse === 1'b1);
    n1 += (t1_pulse === 1'b1);
    r_osc += (dir && !p_osc);
    r_pin += (pin && !p_pin);
    p_osc = dir;
    p_pin = pin;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic cmpv(string n, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmpv
  task automatic cmpi(string n, int e, int g);
    check_count++;
    if (g != e) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmpi
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req <= '0;
  endtask : wr
  task automatic rd(logic [1:0] a, logic [7:0] e);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req <= '0;
    #1 cmpv("rdata", {4'h0, e}, {4'h0, rdata});
  endtask : rd
  task automatic meas();
    @(posedge clk) run <= 1'b0;
    repeat (10) @(posedge clk);
    #1 {n0, n1, r_osc, r_pin} = '0; // clear at start
    @(posedge clk) run <= 1'b1;
    repeat (80) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask : meas
  task automatic results();
    $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CSC_REG_MAIN, CSC_MAIN_RST); // main
    rd(CSC_REG_CHAN, CSC_CHAN_RST); // chan
    cmpv("pads", 12'h000, pads); // pads
    $display("Test reset done");
    wr(CSC_REG_CHAN, 8'hFB); // legal code only
    rd(CSC_REG_CHAN, 8'h0B); // chan upper
    cmpv("pads", 12'h000, pads); // off
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00); // unmapped
    for (int r = 0; r < 4; r++) begin
      wr(CSC_REG_MAIN, {4'hF, r[1:0], 2'h3});
      rd(CSC_REG_MAIN, {4'h8, r[1:0], 2'h1}); // bits
      cmpv("osc_ctl", {8'h0, ctl_exp[r]}, {8'h0, osc_ctl});
    end
    wr(CSC_REG_MAIN, 8'h0C);
    rd(CSC_REG_MAIN, 8'h0C);
    cmpv("osc_ctl", 12'h000, {8'h0, osc_ctl}); // off
    wr(CSC_REG_MAIN, 8'h8C);
    for (int k = 0; k < 12; k++) begin
      wr(CSC_REG_CHAN, k[7:0]);
      rd(CSC_REG_CHAN, k[7:0]); // readback
      cmpv("pads", 12'h001 << k, pads); // pad
    end
    wr(CSC_REG_MAIN, 8'h0C);
    rd(CSC_REG_CHAN, 8'h0B);
    cmpv("pads", 12'h000, pads); // disabled
    @(posedge clk) clk_en <= 1'b0;
    wr(CSC_REG_CHAN, 8'h05);
    clk_en <= 1'b1;
    rd(CSC_REG_CHAN, 8'h0B); // write frozen by enable
    wr(CSC_REG_MAIN, 8'h8D);
    @(posedge clk) idle <= 1'b1;
    repeat (8) @(posedge clk);
    rd(CSC_REG_MAIN, 8'h8F); // sourcing
    @(posedge clk) idle <= 1'b0;
    repeat (8) @(posedge clk);
    rd(CSC_REG_MAIN, 8'h8D); // sinking
    $display("Test registers done");
    repeat (4) @(posedge clk);
    #1 n0 = 0;
    repeat (40) @(posedge clk);
    #1 cmpi("t0 iclk", 40 / CSC_ICLK_DIV, n0); // ignored bit
    @(posedge clk) t0_sel <= 1'b1;
    t1_sel <= CSC_T1_SRC_OSC;
    meas();
    cmpi("t0 osc", r_osc, n0); // osc
    cmpi("t1 osc", r_osc, n1); // osc
    cmpi("osc seen", 10, r_osc); // running
    wr(CSC_REG_MAIN, 8'h8C);
    @(posedge clk) t1_sel <= 2'h0;
    meas();
    cmpi("t0 pin", r_pin, n0); // pin
    cmpi("t1 off", 0, n1); // other code
    wr(CSC_REG_MAIN, 8'h8D);
    @(posedge clk) sleep_mode <= 1'b1;
    t1_sel <= CSC_T1_SRC_OSC;
    meas();
    cmpi("t0 sleep", 0, n0); // halted
    cmpi("t1 sleep", r_osc, n1); // sleep count
    u = n1;
    @(posedge clk) load <= 1'b1;
    meas(); // same time base, pad loaded
    cmpi("t1 loaded", r_osc, n1); // loaded count
    thr = (u + n1) / 2;
    cmpi("touch", 1, int'(n1 < thr && u > thr)); // midway
    @(posedge clk) sleep_mode <= 1'b0;
    load <= 1'b0;
    wr(CSC_REG_MAIN, 8'h81);
    meas();
    cmpi("t0 rng off", 0, n0); // osc off
    cmpi("t1 rng off", 0, n1); // osc off
    $display("Test counts done");
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CSC_REG_MAIN, 8'h00); // second reset
    rd(CSC_REG_CHAN, 8'h00); // second reset
    cmpv("osc_ctl", 12'h000, {8'h0, osc_ctl}); // outputs
    cmpv("pads", 12'h000, pads); // pads after reset
    $display("Test second reset done");
    results();
  end
endmodule : csc_ctrl_bench
